// ---- rtl/ctfw_top.sv ----
// Fault flags, protection lockouts and wake logic of a CAN transceiver
// Behaviour
// - Four shorted TX dominant cycles set bus failure
// - Bus failure shown in normal; cleared normal/power-on
// - Local failure set by four fault events
// - Local failure shown silent; three clear causes
// - Wake request only on filtered wake pattern in low power
// - Pattern is dominant, recessive, dominant phases
// - Pattern time-out restarts wake search
// - Long TX dominant disables transmitter until cleared
// - TX-RX short disables transmitter until cleared
// - Long bus dominant flags; released on recessive
// - Undervoltage holds lockout until supply recovers
// - Overtemperature shuts down until recovery reported
// - Wake phases need about one microsecond minimum
// - Wake pattern window one millisecond
// - TX dominant time-out one millisecond
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
module ctfw_top import ctfw_pkg::*; #(
  parameter int unsigned TXD_DTO_CYCLES = TXD_DTO_CYC,
  parameter int unsigned BUS_DTO_CYCLES = BUS_DTO_CYC,
  parameter int unsigned WAKE_TO_CYCLES = WAKE_TO_CYC
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Pins and analog detectors
  input  wire ctfw_pin_t         pin_in,
  // Device outputs
  output logic                   fault_n,
  output logic                   tx_enable,
  output logic                   wake_req,
  output logic                   supply_low_lockout,
  output logic                   shutdown
);

  localparam logic [CNT_W-1:0] TDTO_LIM = CNT_W'(TXD_DTO_CYCLES);
  localparam logic [CNT_W-1:0] BDTO_LIM = CNT_W'(BUS_DTO_CYCLES);

  // ==========================================================================
  // Pin synchronisers
  ctfw_pin_t sync1_ff, pin_s, txd_prev_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Idle levels, so no detector or edge fires in the cycles after reset
      sync1_ff    <= PIN_IDLE;
      pin_s       <= PIN_IDLE;
      txd_prev_ff <= PIN_IDLE;
    end else begin
      sync1_ff    <= pin_in;
      pin_s       <= sync1_ff;
      txd_prev_ff <= pin_s;
    end
  end

  // ==========================================================================
  // APB slave: one wait state, write and read at the pready edge
  ctfw_mode_t  mode_ff, nxt_mode, mode_prev_ff;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [31:0] stat_word;
  logic        acc_done;
  logic        mapped;

  logic bus_fail_ff, local_fail_ff, tdto_ff, short_ff, busdom_ff, wake_ff;
  logic lockout_ff, shutdown_ff, fault_n_ff, tx_en_ff;

  always_comb begin
    stat_word              = '0;
    stat_word[ST_BUSF]     = bus_fail_ff;
    stat_word[ST_LOCAL]    = local_fail_ff;
    stat_word[ST_TDTO]     = tdto_ff;
    stat_word[ST_SHORT]    = short_ff;
    stat_word[ST_BUSDOM]   = busdom_ff;
    stat_word[ST_WAKE]     = wake_ff;
    stat_word[ST_LOCKOUT]  = lockout_ff;
    stat_word[ST_SHUTDN]   = shutdown_ff;
    mapped      = (paddr == CTRL_OFS) || (paddr == STAT_OFS);
    acc_done    = psel && penable && pready_ff;
    nxt_pready  = psel && penable && !pready_ff;
    nxt_pslverr = nxt_pready && !mapped;
    nxt_prdata  = prdata_ff;
    nxt_mode    = mode_ff;
    if (nxt_pready && !pwrite) begin
      if (paddr == CTRL_OFS) nxt_prdata = {29'h0, mode_ff};
      else if (paddr == STAT_OFS) nxt_prdata = stat_word;
      else nxt_prdata = 32'h0;
    end
    if (acc_done && pwrite && paddr == CTRL_OFS) begin
      // Undefined mode codes are dropped so the mode stays legal
      case (pwdata[MODE_LSB +: 3])
        M_NORMAL, M_SILENT, M_STANDBY, M_GOSLEEP, M_SLEEP:
          nxt_mode = ctfw_mode_t'(pwdata[MODE_LSB +: 3]);
        default: nxt_mode = mode_ff;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
      prdata_ff    <= 32'h0;
      mode_ff      <= CTRL_MODE_RST;
      mode_prev_ff <= CTRL_MODE_RST;
    end else begin
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
      prdata_ff    <= nxt_prdata;
      mode_ff      <= nxt_mode;
      mode_prev_ff <= mode_ff;
    end
  end

  // ==========================================================================
  // Remote wake-up
  logic wake_pulse, low_power;

  assign low_power = (mode_ff == M_STANDBY) || (mode_ff == M_GOSLEEP) || (mode_ff == M_SLEEP);

  ctfw_wake_det #(
    .PHASE_CYC (WAKE_PHASE_CYC),
    .TO_CYC    (WAKE_TO_CYCLES)
  ) u_wake (
    .mclk       (mclk),
    .rst        (rst),
    .enable     (low_power),
    .lp_dom     (!pin_s.lp_rx),
    .wake_pulse (wake_pulse)
  );

  // ==========================================================================
  // Fault flags and protection
  logic [CNT_W-1:0] tdto_cnt_ff, nxt_tdto_cnt, bdto_cnt_ff, nxt_bdto_cnt;
  logic [2:0]       busf_cnt_ff, nxt_busf_cnt;
  logic             seen_ff, nxt_seen;
  logic nxt_bus_fail, nxt_local, nxt_tdto, nxt_short, nxt_busdom, nxt_wake;
  logic nxt_lockout, nxt_shutdown, nxt_fault_n, nxt_tx_en;
  logic enter_normal, pwon_rise, local_evt, local_clr, driving, txd_rise, rx_on;

  always_comb begin
    enter_normal = (mode_ff == M_NORMAL) && (mode_prev_ff != M_NORMAL);
    pwon_rise    = pin_s.pwon && !txd_prev_ff.pwon;
    driving      = tx_en_ff && !pin_s.txd;
    txd_rise     = pin_s.txd && !txd_prev_ff.txd;
    rx_on        = (mode_ff == M_NORMAL) || (mode_ff == M_SILENT);
    // Transmit dominant time-out counter, normal mode only
    nxt_tdto_cnt = '0;
    if (mode_ff == M_NORMAL && !pin_s.txd)
      nxt_tdto_cnt = (tdto_cnt_ff >= TDTO_LIM) ? tdto_cnt_ff : tdto_cnt_ff + 1'b1;
    // Bus dominant time-out counter
    nxt_bdto_cnt = '0;
    if (rx_on && !pin_s.rxd)
      nxt_bdto_cnt = (bdto_cnt_ff >= BDTO_LIM) ? bdto_cnt_ff : bdto_cnt_ff + 1'b1;
    nxt_busdom = rx_on && !pin_s.rxd && (bdto_cnt_ff >= BDTO_LIM);
    // Short seen while driving dominant, counted at each end of a dominant bit
    nxt_seen     = seen_ff || (driving && pin_s.bus_short);
    nxt_busf_cnt = busf_cnt_ff;
    if (txd_rise) begin
      nxt_seen     = 1'b0;
      nxt_busf_cnt = seen_ff ? ((busf_cnt_ff == BUSF_CYCLES) ? busf_cnt_ff
                                : busf_cnt_ff + 1'b1) : 3'h0;
    end
    if (mode_ff != M_NORMAL) begin
      nxt_seen     = 1'b0;
      nxt_busf_cnt = 3'h0;
    end
    // Flags: a set in the clearing cycle wins
    nxt_bus_fail = bus_fail_ff;
    if (enter_normal || pwon_rise) nxt_bus_fail = 1'b0;
    // Set only at the counting edge, so a saturated count cannot mask a clear
    if (txd_rise && nxt_busf_cnt == BUSF_CYCLES) nxt_bus_fail = 1'b1;
    local_clr = enter_normal || pwon_rise || (!pin_s.rxd && pin_s.txd);
    nxt_tdto  = tdto_ff && !local_clr;
    nxt_short = short_ff && !local_clr;
    if (tdto_cnt_ff >= TDTO_LIM) nxt_tdto = 1'b1;
    if (pin_s.txrx_short) nxt_short = 1'b1;
    local_evt = (tdto_cnt_ff >= TDTO_LIM) || pin_s.txrx_short || nxt_busdom
                || pin_s.ot_alarm;
    nxt_local = local_evt || (local_fail_ff && !local_clr);
    // Wake flag held until normal mode is entered
    nxt_wake = (wake_ff && !enter_normal) || wake_pulse;
    nxt_lockout  = pin_s.uv;
    nxt_shutdown = pin_s.ot_alarm || (shutdown_ff && !pin_s.ot_clear);
    nxt_tx_en = (mode_ff == M_NORMAL) && !nxt_tdto && !nxt_short && !nxt_lockout
                && !nxt_shutdown;
    nxt_fault_n = !(((mode_ff == M_NORMAL) && bus_fail_ff)
                    || ((mode_ff == M_SILENT) && local_fail_ff));
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tdto_cnt_ff   <= '0;
      bdto_cnt_ff   <= '0;
      busf_cnt_ff   <= 3'h0;
      seen_ff       <= 1'b0;
      bus_fail_ff   <= 1'b0;
      local_fail_ff <= 1'b0;
      tdto_ff       <= 1'b0;
      short_ff      <= 1'b0;
      busdom_ff     <= 1'b0;
      wake_ff       <= 1'b0;
      lockout_ff    <= 1'b0;
      shutdown_ff   <= 1'b0;
      fault_n_ff    <= 1'b1;
      tx_en_ff      <= 1'b0;
    end else begin
      tdto_cnt_ff   <= nxt_tdto_cnt;
      bdto_cnt_ff   <= nxt_bdto_cnt;
      busf_cnt_ff   <= nxt_busf_cnt;
      seen_ff       <= nxt_seen;
      bus_fail_ff   <= nxt_bus_fail;
      local_fail_ff <= nxt_local;
      tdto_ff       <= nxt_tdto;
      short_ff      <= nxt_short;
      busdom_ff     <= nxt_busdom;
      wake_ff       <= nxt_wake;
      lockout_ff    <= nxt_lockout;
      shutdown_ff   <= nxt_shutdown;
      fault_n_ff    <= nxt_fault_n;
      tx_en_ff      <= nxt_tx_en;
    end
  end

  assign prdata             = prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;
  assign fault_n            = fault_n_ff;
  assign tx_enable          = tx_en_ff;
  assign wake_req           = wake_ff;
  assign supply_low_lockout = lockout_ff;
  assign shutdown           = shutdown_ff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_busf_four: assert property (
    $rose(bus_fail_ff) |-> $past(busf_cnt_ff) >= 3'h3 && $past(txd_rise))
    else $error("bus failure set before four shorted cycles");
  chk_busf_fault: assert property (
    (mode_ff == M_NORMAL && bus_fail_ff) |=> !fault_n_ff)
    else $error("bus failure not on fault output in normal");
  chk_local_set: assert property (
    pin_s.ot_alarm |=> local_fail_ff && shutdown_ff)
    else $error("overtemperature did not set local failure");
  chk_local_clear: assert property (
    (local_fail_ff && enter_normal && !local_evt) |=> !local_fail_ff ##1 fault_n_ff)
    else $error("local failure not cleared on normal entry");
  chk_tdto_block: assert property (
    (mode_ff == M_NORMAL && tdto_cnt_ff >= TDTO_LIM) |=> tdto_ff && !tx_en_ff)
    else $error("transmitter left on after dominant time-out");
  chk_short_block: assert property (
    short_ff |-> !tx_en_ff)
    else $error("transmitter on during tx-rx short");
  chk_busdom_release: assert property (
    (busdom_ff && pin_s.rxd) |=> !busdom_ff)
    else $error("bus dominant flag not released");
  chk_lockout_hold: assert property (
    pin_s.uv [*2] |-> lockout_ff && !tx_en_ff)
    else $error("undervoltage lockout not held");
  chk_shutdown_hold: assert property (
    (shutdown_ff && !pin_s.ot_clear) |=> shutdown_ff)
    else $error("shutdown released without recovery");
  chk_apb_wait: assert property (
    (psel && penable && !pready_ff) |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not one wait state");

  cov_bus_fail: cover property ($rose(bus_fail_ff));
  cov_local_silent: cover property (mode_ff == M_SILENT && !fault_n_ff);
  cov_tdto: cover property ($rose(tdto_ff));
  cov_wake_req: cover property ($rose(wake_ff));

endmodule // ctfw_top

// ---- rtl/ctfw_pkg.sv ----
// Constants, mode codes and pin bundle of the transceiver fault and wake logic
package ctfw_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_NS        = 10;
  localparam int WAKE_PHASE_NS = 1000;
  localparam int WAKE_PHASE_CYC = (WAKE_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_TO_US    = 1000;
  localparam int WAKE_TO_CYC   = WAKE_TO_US * 1000 / CLK_NS;
  localparam int TXD_DTO_US    = 1000;
  localparam int TXD_DTO_CYC   = (TXD_DTO_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int BUS_DTO_US    = 1000;
  localparam int BUS_DTO_CYC   = (BUS_DTO_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] BUSF_CYCLES = 3'h4;
  localparam int CNT_W         = 17;
  localparam int PH_W          = 8;

  // ==========================================================================
  // Register map
  localparam int ADDR_W            = 8;
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam int MODE_LSB          = 0;
  localparam int ST_BUSF           = 0;
  localparam int ST_LOCAL          = 1;
  localparam int ST_TDTO           = 2;
  localparam int ST_SHORT          = 3;
  localparam int ST_BUSDOM         = 4;
  localparam int ST_WAKE           = 5;
  localparam int ST_LOCKOUT        = 6;
  localparam int ST_SHUTDN         = 7;

  typedef enum logic [2:0] {
    M_NORMAL  = 3'b000,
    M_SILENT  = 3'b001,
    M_STANDBY = 3'b010,
    M_GOSLEEP = 3'b011,
    M_SLEEP   = 3'b100
  } ctfw_mode_t;

  localparam ctfw_mode_t CTRL_MODE_RST = M_STANDBY;

  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_DOM1 = 2'b01,
    W_REC  = 2'b10,
    W_DOM2 = 2'b11
  } ctfw_wake_st_t;

  // Pin levels: 0 on txd, rxd, lp_rx means dominant
  typedef struct packed {
    logic txd;
    logic rxd;
    logic lp_rx;
    logic bus_short;
    logic txrx_short;
    logic uv;
    logic ot_alarm;
    logic ot_clear;
    logic pwon;
  } ctfw_pin_t;

  // Idle pin levels: lines recessive, detectors quiet
  localparam ctfw_pin_t PIN_IDLE = '{txd: 1'b1, rxd: 1'b1, lp_rx: 1'b1, default: 1'b0};

endpackage

// ---- rtl/ctfw_wake_det.sv ----
// Filtered remote wake-up pattern detector
`timescale 1ns/10ps
module ctfw_wake_det import ctfw_pkg::*; #(
  parameter int unsigned PHASE_CYC = WAKE_PHASE_CYC,
  parameter int unsigned TO_CYC    = WAKE_TO_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Detector control and line
  input  wire logic enable,
  input  wire logic lp_dom,
  // Result
  output logic      wake_pulse
);

  localparam logic [PH_W-1:0]  PH_MIN  = PH_W'(PHASE_CYC);
  localparam logic [CNT_W-1:0] WIN_MAX = CNT_W'(TO_CYC);

  ctfw_wake_st_t    st_ff, nxt_st;
  logic [PH_W-1:0]  ph_ff, nxt_ph;
  logic [CNT_W-1:0] win_ff, nxt_win;
  logic             wake_ff, nxt_wake;
  logic             qual;
  logic [PH_W-1:0]  ph_inc;

  // ==========================================================================
  // Pattern sequencer
  always_comb begin
    qual     = (ph_ff >= PH_MIN);
    ph_inc   = (ph_ff == '1) ? ph_ff : ph_ff + 1'b1;
    nxt_st   = st_ff;
    nxt_ph   = ph_ff;
    nxt_win  = win_ff + 1'b1;
    nxt_wake = 1'b0;
    if (!enable) begin
      nxt_st  = W_IDLE;
      nxt_ph  = '0;
      nxt_win = '0;
    end else if (st_ff != W_IDLE && win_ff >= WIN_MAX) begin
      nxt_st  = W_IDLE;
      nxt_win = '0;
    end else begin
      case (st_ff)
        W_IDLE: begin
          nxt_win = '0;
          if (lp_dom) begin
            nxt_st  = W_DOM1;
            nxt_ph  = 8'h01;
            nxt_win = 17'h00001;
          end
        end
        W_DOM1: begin
          if (lp_dom) nxt_ph = ph_inc;
          else if (qual) begin
            nxt_st = W_REC;
            nxt_ph = 8'h01;
          end else nxt_st = W_IDLE;
        end
        W_REC: begin
          if (!lp_dom) nxt_ph = ph_inc;
          else if (qual) begin
            nxt_st = W_DOM2;
            nxt_ph = 8'h01;
          end else nxt_st = W_IDLE;
        end
        W_DOM2: begin
          if (!lp_dom) nxt_st = W_IDLE;
          else if (ph_inc >= PH_MIN) begin
            nxt_wake = 1'b1;
            nxt_st   = W_IDLE;
          end else nxt_ph = ph_inc;
        end
        default: nxt_st = W_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff   <= W_IDLE;
      ph_ff   <= '0;
      win_ff  <= '0;
      wake_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      ph_ff   <= nxt_ph;
      win_ff  <= nxt_win;
      wake_ff <= nxt_wake;
    end
  end

  assign wake_pulse = wake_ff;

  // ==========================================================================
  // Checks
  chk_wake_final_dom: assert property (@(posedge mclk) disable iff (rst)
    wake_ff |-> $past(st_ff) == W_DOM2 && $past(lp_dom))
    else $error("wake without a final dominant phase");
  chk_wake_timeout: assert property (@(posedge mclk) disable iff (rst)
    (enable && st_ff != W_IDLE && win_ff >= WIN_MAX) |=> st_ff == W_IDLE && !wake_ff)
    else $error("wake window not reset at time-out");
  chk_short_phase: assert property (@(posedge mclk) disable iff (rst)
    (enable && st_ff == W_DOM1 && !lp_dom && !qual && win_ff < WIN_MAX)
      |=> st_ff == W_IDLE)
    else $error("short dominant phase accepted");
  cov_wake: cover property (@(posedge mclk) disable iff (rst) wake_ff);

endmodule // ctfw_wake_det

// ---- sim/ctfw_bus_model.sv ----
// Far-side model: host TX pin, CAN bus lines and analog detectors
`timescale 1ns/10ps
module ctfw_bus_model import ctfw_pkg::*; (
  // Clock
  input  wire logic mclk,
  // Pin levels towards the block
  output ctfw_pin_t pin
);
  // ==========================================================================
  // Idle: lines recessive, detectors quiet
  initial begin
    pin = '{txd: 1'b1, rxd: 1'b1, lp_rx: 1'b1, default: 1'b0};
  end

  // ==========================================================================
  // Low-power receiver: dominant, recessive, dominant phases in cycles
  task automatic wake(input int d1, input int rc, input int d2);
    @(posedge mclk) pin.lp_rx <= 1'b0;
    repeat (d1) @(posedge mclk);
    pin.lp_rx <= 1'b1;
    repeat (rc) @(posedge mclk);
    pin.lp_rx <= 1'b0;
    repeat (d2) @(posedge mclk);
    pin.lp_rx <= 1'b1;
  endtask

  // TX bits; a shorted bus line reports the short while the bit is dominant
  task automatic tx_bits(input int n, input logic sh);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk) pin.txd <= 1'b0;
      pin.bus_short <= sh;
      repeat (5) @(posedge mclk);
      pin.txd       <= 1'b1;
      pin.bus_short <= 1'b0;
      repeat (5) @(posedge mclk);
    end
  endtask
endmodule // ctfw_bus_model

// ---- sim/ctfw_tb_top.sv ----
// Self-checking bench of the transceiver fault and wake logic
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module ctfw_tb_top import ctfw_pkg::*;;
  logic              mclk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic [31:0]       q;
  logic              pready;
  logic              pslverr;
  logic              e;
  ctfw_pin_t         pin_in;
  logic              fault_n;
  logic              tx_enable;
  logic              wake_req;
  logic              supply_low_lockout;
  logic              shutdown;
  int                n_fail;
  int                total_checks;
  int                cyc;

  // ==========================================================================
  // Design and far side
  ctfw_top #(.TXD_DTO_CYCLES(200), .BUS_DTO_CYCLES(200), .WAKE_TO_CYCLES(1000)) u_ctfw_top (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .fault_n(fault_n), .tx_enable(tx_enable),
    .wake_req(wake_req), .supply_low_lockout(supply_low_lockout), .shutdown(shutdown));
  ctfw_bus_model u_ctfw_bus_model (.mclk(mclk), .pin(pin_in));

  // ==========================================================================
  // Clock, reset, timeout
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk) cyc++;
      if (cyc == 40000) begin
        n_fail++;
        stop_test();
      end
    end
  end

  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // APB master: request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) psel <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk) penable <= 1'b1;
    // Only the bench timeout ends a hung wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic mode(input ctfw_mode_t m);
    xfer(1'b1, CTRL_OFS, {29'h0, m});
  endtask

  task automatic stat(input int b, input logic x);
    xfer(1'b0, STAT_OFS, 32'h0);
    `CHK("stat bit", x, q[b])
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // ==========================================================================
  // Tests
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    total_checks = 0;
    tick(5);
    rst <= 1'b0;
    tick(4);
    `CHK("fault_n", 1'b1, fault_n)
    `CHK("tx_enable", 1'b0, tx_enable)
    xfer(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl reset", 32'h0000_0002, q)
    xfer(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    xfer(1'b1, STAT_OFS, 32'hFFFF_FFFF);
    xfer(1'b0, STAT_OFS, 32'h0);
    `CHK("stat ro", 32'h0, q)
    for (int m = 4; m >= 0; m--) begin
      mode(ctfw_mode_t'(m));
      xfer(1'b0, CTRL_OFS, 32'h0);
      `CHK("ctrl mode", 32'(m), q)
    end
    xfer(1'b1, CTRL_OFS, 32'h0000_0005);
    xfer(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl bad code", 32'h0, q)
    mode(M_STANDBY);
    // Remote wake pattern, minimal-margin phases
    u_ctfw_bus_model.wake(110, 110, 110);
    tick(6);
    `CHK("wake_req", 1'b1, wake_req)
    stat(ST_WAKE, 1'b1);
    mode(M_NORMAL);
    u_ctfw_bus_model.wake(110, 110, 110);
    tick(6);
    `CHK("wake_req normal", 1'b0, wake_req)
    mode(M_SLEEP);
    u_ctfw_bus_model.wake(50, 110, 110);
    tick(6);
    `CHK("wake short phase", 1'b0, wake_req)
    u_ctfw_bus_model.wake(110, 900, 110);
    tick(6);
    `CHK("wake timeout", 1'b0, wake_req)
    // Bus failure: count restarts on a bit without short
    mode(M_NORMAL);
    tick(4);
    `CHK("tx_enable", 1'b1, tx_enable)
    u_ctfw_bus_model.tx_bits(3, 1'b1);
    u_ctfw_bus_model.tx_bits(1, 1'b0);
    u_ctfw_bus_model.tx_bits(3, 1'b1);
    tick(4);
    `CHK("busf three", 1'b1, fault_n)
    u_ctfw_bus_model.tx_bits(1, 1'b1);
    tick(4);
    `CHK("busf four", 1'b0, fault_n)
    mode(M_SILENT);
    tick(4);
    `CHK("busf silent", 1'b1, fault_n)
    mode(M_NORMAL);
    tick(4);
    `CHK("busf reentry", 1'b1, fault_n)
    u_ctfw_bus_model.tx_bits(4, 1'b1);
    @(posedge mclk) u_ctfw_bus_model.pin.pwon <= 1'b1;
    tick(3);
    u_ctfw_bus_model.pin.pwon <= 1'b0;
    tick(6);
    `CHK("busf pwon", 1'b1, fault_n)
    // TX dominant time-out
    u_ctfw_bus_model.pin.txd <= 1'b0;
    tick(150);
    `CHK("tdto early", 1'b1, tx_enable)
    tick(100);
    `CHK("tdto", 1'b0, tx_enable)
    u_ctfw_bus_model.pin.txd <= 1'b1;
    tick(10);
    `CHK("tdto held", 1'b0, tx_enable)
    stat(ST_TDTO, 1'b1);
    stat(ST_LOCAL, 1'b1);
    mode(M_SILENT);
    tick(4);
    `CHK("local silent", 1'b0, fault_n)
    @(posedge mclk) u_ctfw_bus_model.pin.rxd <= 1'b0;
    tick(5);
    u_ctfw_bus_model.pin.rxd <= 1'b1;
    tick(6);
    `CHK("local rxd clr", 1'b1, fault_n)
    mode(M_NORMAL);
    tick(4);
    `CHK("tdto cleared", 1'b1, tx_enable)
    // TX-to-RX short
    @(posedge mclk) u_ctfw_bus_model.pin.txrx_short <= 1'b1;
    tick(3);
    u_ctfw_bus_model.pin.txrx_short <= 1'b0;
    tick(20);
    `CHK("short", 1'b0, tx_enable)
    stat(ST_SHORT, 1'b1);
    mode(M_SILENT);
    mode(M_NORMAL);
    tick(4);
    `CHK("short cleared", 1'b1, tx_enable)
    // Bus dominant time-out
    mode(M_SILENT);
    @(posedge mclk) u_ctfw_bus_model.pin.rxd <= 1'b0;
    tick(140);
    stat(ST_BUSDOM, 1'b0);
    tick(100);
    stat(ST_BUSDOM, 1'b1);
    `CHK("busdom local", 1'b0, fault_n)
    u_ctfw_bus_model.pin.rxd <= 1'b1;
    tick(6);
    stat(ST_BUSDOM, 1'b0);
    // Undervoltage and overtemperature
    mode(M_NORMAL);
    @(posedge mclk) u_ctfw_bus_model.pin.uv <= 1'b1;
    tick(6);
    `CHK("uv lock", 1'b1, supply_low_lockout)
    `CHK("uv tx", 1'b0, tx_enable)
    u_ctfw_bus_model.pin.uv <= 1'b0;
    tick(6);
    `CHK("uv free", 1'b0, supply_low_lockout)
    `CHK("uv tx back", 1'b1, tx_enable)
    u_ctfw_bus_model.pin.ot_alarm <= 1'b1;
    tick(6);
    `CHK("ot", 1'b1, shutdown)
    `CHK("ot tx", 1'b0, tx_enable)
    stat(ST_LOCAL, 1'b1);
    u_ctfw_bus_model.pin.ot_alarm <= 1'b0;
    tick(10);
    `CHK("ot held", 1'b1, shutdown)
    u_ctfw_bus_model.pin.ot_clear <= 1'b1;
    tick(6);
    `CHK("ot clear", 1'b0, shutdown)
    u_ctfw_bus_model.pin.ot_clear <= 1'b0;
    tick(4);
    stop_test();
  end
endmodule // ctfw_tb_top
